// ---- inc/swd_defs.vh ----
// Constants for the signed word divide unit
`ifndef SWD_DEFS_VH
`define SWD_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SWD_ADDR_W        4
`define SWD_REG_CTRL      4'h0
`define SWD_REG_DIVIDEND  4'h1
`define SWD_REG_DIVISOR   4'h2
`define SWD_REG_TARGET    4'h3
`define SWD_REG_AUXQ      4'h4
`define SWD_REG_FLAGS     4'h5
`define SWD_REG_IRQ_STAT  4'h6
`define SWD_REG_IRQ_EN    4'h7
`define SWD_REG_IRQ_CLR   4'h8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SWD_CTRL_START    0
`define SWD_CTRL_SHORT    1
`define SWD_CTRL_OE       2
`define SWD_CTRL_RC       3

// ----------------------------------------
// Flags register fields
// ----------------------------------------
`define SWD_FLG_SO        0
`define SWD_FLG_OV        1
`define SWD_FLG_CA        2
`define SWD_FLG_LT        3
`define SWD_FLG_GT        4
`define SWD_FLG_EQ        5
`define SWD_FLG_CRSO      6
`define SWD_FLG_BUSY      7
`define SWD_FLG_W         8

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define SWD_IRQ_DONE      0
`define SWD_IRQ_OVF       1
`define SWD_IRQ_ILLEGAL   2
`define SWD_IRQ_W         3

// ----------------------------------------
// Values
// ----------------------------------------
`define SWD_MOST_NEG      32'h80000000
`define SWD_MINUS_ONE     32'hFFFFFFFF
`define SWD_ZERO32        32'h00000000
`define SWD_FAMILY_OLD    1'b0
`define SWD_FAMILY_NEW    1'b1

`endif

// ---- rtl/swd_divcore.v ----
// Sequential unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
`default_nettype none

module swd_divcore #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             ref_clk_in,
   input  wire             reset_n_in,
   // Request
   input  wire             start_in,
   input  wire [WIDTH-1:0] dividend_in,
   input  wire [WIDTH-1:0] divisor_in,
   // Answer
   output reg              done_out,
   output reg  [WIDTH-1:0] quotient_out,
   output reg  [WIDTH-1:0] remainder_out,
   output wire             busy_out
);

   localparam CW = 6;

   reg  [CW-1:0]    count;
   reg  [WIDTH-1:0] dvsr;
   reg              running;
   wire [WIDTH:0]   trial;

   assign busy_out = running;
   assign trial    = {remainder_out, quotient_out[WIDTH-1]} - {1'b0, dvsr};

   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         count         <= {CW{1'b0}};
         dvsr          <= {WIDTH{1'b0}};
         running       <= 1'b0;
         done_out      <= 1'b0;
         quotient_out  <= {WIDTH{1'b0}};
         remainder_out <= {WIDTH{1'b0}};
      end
      else
      begin
         done_out <= 1'b0;
         if (start_in && !running)
         begin
            quotient_out  <= dividend_in;
            remainder_out <= {WIDTH{1'b0}};
            dvsr          <= divisor_in;
            count         <= WIDTH[CW-1:0];
            running       <= 1'b1;
         end
         else if (running)
         begin
            // Shift in next dividend bit, keep trial difference when non-negative
            if (!trial[WIDTH])
               remainder_out <= trial[WIDTH-1:0];
            else
               remainder_out <= {remainder_out[WIDTH-2:0], quotient_out[WIDTH-1]};
            quotient_out <= {quotient_out[WIDTH-2:0], ~trial[WIDTH]};
            count        <= count - 1'b1;
            if (count == 1)
            begin
               running  <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end

endmodule // swd_divcore

`default_nettype wire

// ---- rtl/swd_divide_unit.v ----
// Signed word divide unit: short divide and word divide with status flags
`timescale 1ns/1ns
`default_nettype none
`include "swd_defs.vh"

module swd_divide_unit #(
   parameter       WIDTH  = 32,
   parameter [0:0] FAMILY = `SWD_FAMILY_OLD
) (
   // Clock and reset
   input  wire                   ref_clk_in,
   input  wire                   reset_n_in,
   // Register port
   input  wire [`SWD_ADDR_W-1:0] addr_in,
   input  wire [31:0]            wdata_in,
   input  wire                   write_in,
   input  wire                   read_in,
   output reg  [31:0]            rdata_out,
   // Status outputs
   output wire                   busy_out,
   output wire                   irq_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN  = 2'b01;
   localparam ST_DONE = 2'b10;

   reg  [1:0]       state;
   reg  [1:0]       next_state;
   reg  [WIDTH-1:0] dividend_reg;
   reg  [WIDTH-1:0] divisor_reg;
   reg  [WIDTH-1:0] target_reg;
   reg  [WIDTH-1:0] aux_quotient_reg;
   reg              op_short;
   reg              op_oe;
   reg              op_rc;
   reg              summary_ovf_bit;
   reg              overflow_bit;
   reg              carry_bit;
   reg              negative_result_bit;
   reg              positive_result_bit;
   reg              zero_result_bit;
   reg              cr_summary_bit;
   reg  [`SWD_IRQ_W-1:0] irq_en;
   reg  [31:0]           next_rdata;

   wire [`SWD_IRQ_W-1:0] irq_stat;
   reg  [`SWD_IRQ_W-1:0] irq_event;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   wire ctrl_wr   = write_in && (addr_in == `SWD_REG_CTRL);
   wire cmd_short = wdata_in[`SWD_CTRL_SHORT];
   // Only the op matching the build family is a valid divide
   wire cmd_legal = cmd_short ? (FAMILY == `SWD_FAMILY_OLD)
                              : (FAMILY == `SWD_FAMILY_NEW);
   wire cmd_start = ctrl_wr && wdata_in[`SWD_CTRL_START] && (state == ST_IDLE);
   wire launch    = cmd_start && cmd_legal;

   // ----------------------------------------
   // Register write decode
   // ----------------------------------------
   // Operand, auxiliary and flag writes only land while idle, so a divide never sees them change
   wire wr_idle     = write_in && (state == ST_IDLE);
   wire wr_dividend = wr_idle && (addr_in == `SWD_REG_DIVIDEND);
   wire wr_divisor  = wr_idle && (addr_in == `SWD_REG_DIVISOR);
   wire wr_auxq     = wr_idle && (addr_in == `SWD_REG_AUXQ);
   wire wr_flags    = wr_idle && (addr_in == `SWD_REG_FLAGS);
   wire wr_irq_en   = write_in && (addr_in == `SWD_REG_IRQ_EN);
   wire wr_irq_clr  = write_in && (addr_in == `SWD_REG_IRQ_CLR);

   // ----------------------------------------
   // Magnitude divide
   // ----------------------------------------
   // One quotient bit per cycle keeps the core small at the price of a long latency
   wire             a_neg = dividend_reg[WIDTH-1];
   wire             b_neg = divisor_reg[WIDTH-1];
   wire [WIDTH-1:0] a_mag = a_neg ? (~dividend_reg + 1'b1) : dividend_reg;
   wire [WIDTH-1:0] b_mag = b_neg ? (~divisor_reg + 1'b1) : divisor_reg;
   wire [WIDTH-1:0] u_quo;
   wire [WIDTH-1:0] u_rem;
   wire             core_done;

   swd_divcore #(
      .WIDTH (WIDTH)
   ) u_core (
      .ref_clk_in    (ref_clk_in),
      .reset_n_in    (reset_n_in),
      .start_in      (state == ST_IDLE && next_state == ST_RUN),
      .dividend_in   (a_mag),
      .divisor_in    (b_mag),
      .done_out      (core_done),
      .quotient_out  (u_quo),
      .remainder_out (u_rem),
      .busy_out      ()
   );

   // ----------------------------------------
   // Signed result and overflow
   // ----------------------------------------
   wire div_zero   = (divisor_reg == `SWD_ZERO32);
   wire min_by_m1  = (dividend_reg == `SWD_MOST_NEG) && (divisor_reg == `SWD_MINUS_ONE);
   wire ovf        = div_zero || min_by_m1;
   wire [WIDTH-1:0] s_quo = (a_neg ^ b_neg) ? (~u_quo + 1'b1) : u_quo;
   // Negating a zero magnitude stays zero, so zeros come out positive
   wire [WIDTH-1:0] s_rem = a_neg ? (~u_rem + 1'b1) : u_rem;
   // Short divide special case pins both results; word divide keeps whatever
   wire [WIDTH-1:0] res_quo = (op_short && min_by_m1) ? `SWD_MOST_NEG : s_quo;
   wire [WIDTH-1:0] res_rem = (op_short && min_by_m1) ? `SWD_ZERO32 : s_rem;
   wire             so_next = summary_ovf_bit | (op_oe & ovf);

   // ----------------------------------------
   // Record field
   // ----------------------------------------
   // On an undefined overflow result these follow whatever quotient came out
   wire rec_neg  = res_quo[WIDTH-1];
   wire rec_zero = (res_quo == `SWD_ZERO32);
   wire rec_pos  = !rec_neg && !rec_zero;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (launch)
               next_state = ST_RUN;
         ST_RUN:
            if (core_done)
               next_state = ST_DONE;
         ST_DONE:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   // Overflow is flagged whatever the overflow enable says; software masks it if unwanted
   always @*
   begin
      irq_event = {`SWD_IRQ_W{1'b0}};
      irq_event[`SWD_IRQ_DONE]    = core_done;
      irq_event[`SWD_IRQ_OVF]     = core_done && ovf;
      irq_event[`SWD_IRQ_ILLEGAL] = cmd_start && !cmd_legal;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Done is a one-cycle write-back slot; a start written there is ignored
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // ----------------------------------------
   // Operands and command latch
   // ----------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         dividend_reg <= {WIDTH{1'b0}};
         divisor_reg  <= {WIDTH{1'b0}};
         op_short     <= 1'b0;
         op_oe        <= 1'b0;
         op_rc        <= 1'b0;
         irq_en       <= {`SWD_IRQ_W{1'b0}};
      end
      else
      begin
         if (wr_dividend)
            dividend_reg <= wdata_in[WIDTH-1:0];
         if (wr_divisor)
            divisor_reg <= wdata_in[WIDTH-1:0];
         if (wr_irq_en)
            irq_en <= wdata_in[`SWD_IRQ_W-1:0];
         // Form flags are held for the whole divide; the bus may move on meanwhile
         if (launch)
         begin
            op_short <= cmd_short;
            op_oe    <= wdata_in[`SWD_CTRL_OE];
            op_rc    <= wdata_in[`SWD_CTRL_RC];
         end
      end
   end

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         target_reg       <= {WIDTH{1'b0}};
         aux_quotient_reg <= {WIDTH{1'b0}};
      end
      else if (core_done)
      begin
         target_reg <= res_quo;
         // Word divide leaves the auxiliary quotient as software wrote it
         if (op_short)
            aux_quotient_reg <= res_rem;
      end
      else if (wr_auxq)
         aux_quotient_reg <= wdata_in[WIDTH-1:0];
   end

   // ----------------------------------------
   // Status and compare flags
   // ----------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         summary_ovf_bit     <= 1'b0;
         overflow_bit        <= 1'b0;
         carry_bit           <= 1'b0;
         negative_result_bit <= 1'b0;
         positive_result_bit <= 1'b0;
         zero_result_bit     <= 1'b0;
         cr_summary_bit      <= 1'b0;
      end
      else if (core_done)
      begin
         if (op_oe)
         begin
            overflow_bit    <= ovf;
            summary_ovf_bit <= so_next;
         end
         if (op_rc)
         begin
            negative_result_bit <= rec_neg;
            positive_result_bit <= rec_pos;
            zero_result_bit     <= rec_zero;
            cr_summary_bit      <= so_next;
         end
         // carry_bit left alone here on purpose
      end
      else if (wr_flags)
      begin
         // Software owns carry; only this write ever changes it
         summary_ovf_bit     <= wdata_in[`SWD_FLG_SO];
         overflow_bit        <= wdata_in[`SWD_FLG_OV];
         carry_bit           <= wdata_in[`SWD_FLG_CA];
         negative_result_bit <= wdata_in[`SWD_FLG_LT];
         positive_result_bit <= wdata_in[`SWD_FLG_GT];
         zero_result_bit     <= wdata_in[`SWD_FLG_EQ];
         cr_summary_bit      <= wdata_in[`SWD_FLG_CRSO];
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   swd_irq #(
      .N (`SWD_IRQ_W)
   ) u_irq (
      .ref_clk_in  (ref_clk_in),
      .reset_n_in  (reset_n_in),
      .event_in    (irq_event),
      .clear_in    (wdata_in[`SWD_IRQ_W-1:0]),
      .clear_we_in (wr_irq_clr),
      .enable_in   (irq_en),
      .status_out  (irq_stat),
      .irq_out     (irq_out)
   );

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Busy also covers the write-back slot, in which a start would be ignored
   assign busy_out = (state != ST_IDLE);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Unmapped and write-only addresses read as zero
   always @*
   begin
      next_rdata = 32'h00000000;
      if (read_in)
      begin
         case (addr_in)
            `SWD_REG_CTRL:     next_rdata = {28'h0000000, op_rc, op_oe, op_short, busy_out};
            `SWD_REG_DIVIDEND: next_rdata = dividend_reg;
            `SWD_REG_DIVISOR:  next_rdata = divisor_reg;
            `SWD_REG_TARGET:   next_rdata = target_reg;
            `SWD_REG_AUXQ:     next_rdata = aux_quotient_reg;
            `SWD_REG_FLAGS:    next_rdata = {24'h000000, busy_out, cr_summary_bit, zero_result_bit,
                                             positive_result_bit, negative_result_bit, carry_bit,
                                             overflow_bit, summary_ovf_bit};
            `SWD_REG_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
            `SWD_REG_IRQ_EN:   next_rdata = {29'h00000000, irq_en};
            default:           next_rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Read data stand for one cycle only, then fall back to zero
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rdata_out <= 32'h00000000;
      else
         rdata_out <= next_rdata;
   end

endmodule // swd_divide_unit

`default_nettype wire

// ---- rtl/swd_irq.v ----
// Sticky interrupt status with enable mask and write-one-to-clear
`timescale 1ns/1ns
`default_nettype none

module swd_irq #(
   parameter N = 3
) (
   // Clock and reset
   input  wire         ref_clk_in,
   input  wire         reset_n_in,
   // Events and software
   input  wire [N-1:0] event_in,
   input  wire [N-1:0] clear_in,
   input  wire         clear_we_in,
   input  wire [N-1:0] enable_in,
   // Results
   output reg  [N-1:0] status_out,
   output wire         irq_out
);

   assign irq_out = |(status_out & enable_in);

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_bit
         always @(posedge ref_clk_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
               status_out[i] <= 1'b0;
            else if (event_in[i])
               status_out[i] <= 1'b1;   // Set beats a same-cycle clear
            else if (clear_we_in && clear_in[i])
               status_out[i] <= 1'b0;
         end
      end
   endgenerate

endmodule // swd_irq

`default_nettype wire

// ---- testbench/swd_divide_unit_tb_top.sv ----
// Testbench for the signed word divide unit, both families side by side
`timescale 1ns/1ns
`default_nettype none
`include "swd_defs.vh"

module swd_divide_unit_tb_top;
   logic            ref_clk_in = 1'b0;
   logic            reset_n_in = 1'b0;
   wire logic [3:0] addr;
   wire logic [31:0] wdata, rdata_old, rdata_new;
   wire logic       write, read, busy_old, busy_new, irq_old, irq_new;
   int              fail_count = 0;
   int              n_compared = 0;

   always #5 ref_clk_in = ~ref_clk_in;

   swd_host_model swd_host_model_i (.ref_clk_in(ref_clk_in), .addr_out(addr), .wdata_out(wdata),
      .write_out(write), .read_out(read), .rdata_old_in(rdata_old), .rdata_new_in(rdata_new));
   swd_divide_unit #(.FAMILY(`SWD_FAMILY_OLD)) swd_divide_unit_i (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .write_in(write), .read_in(read),
      .rdata_out(rdata_old), .busy_out(busy_old), .irq_out(irq_old));
   swd_divide_unit #(.FAMILY(`SWD_FAMILY_NEW)) swd_divide_unit_new_i (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .write_in(write), .read_in(read),
      .rdata_out(rdata_new), .busy_out(busy_new), .irq_out(irq_new));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdx(input logic sel, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      swd_host_model_i.rd(sel, a, d);
      chk(d, exp);
   endtask

   // Operands and control go to both units; each obeys its own family
   task automatic op(input logic [31:0] dd, input logic [31:0] dv, input logic [31:0] ctrl);
      int i;
      swd_host_model_i.wr(`SWD_REG_DIVIDEND, dd);
      swd_host_model_i.wr(`SWD_REG_DIVISOR, dv);
      swd_host_model_i.wr(`SWD_REG_CTRL, ctrl);
      repeat (2) @(posedge ref_clk_in);
      for (i = 0; i < 60 && (busy_old !== 1'b0 || busy_new !== 1'b0); i++)
         @(posedge ref_clk_in);
      chk({30'h0, busy_old, busy_new}, 32'h0);
   endtask

   task automatic t_short;
      logic [31:0] dd[6] = '{32'h7, 32'hFFFFFFF9, 32'h7, 32'hFFFFFFF8, 32'h1, `SWD_MOST_NEG};
      logic [31:0] dv[6] = '{32'h2, 32'h2, 32'hFFFFFFFE, 32'h2, 32'h2, `SWD_MINUS_ONE};
      logic [31:0] q, r;
      for (int i = 0; i < 6; i++)
      begin
         // Both arms signed, else the divide is done unsigned
         q = (i == 5) ? $signed(`SWD_MOST_NEG) : $signed(dd[i]) / $signed(dv[i]);
         r = (i == 5) ? $signed(`SWD_ZERO32) : $signed(dd[i]) % $signed(dv[i]);
         op(dd[i], dv[i], 32'h3);
         rdx(1'b0, `SWD_REG_TARGET, q);
         rdx(1'b0, `SWD_REG_AUXQ, r);
      end
      // Most negative by minus one also raises the overflow event
      rdx(1'b0, `SWD_REG_IRQ_STAT, 32'h3);
      rdx(1'b1, `SWD_REG_IRQ_STAT, 32'h4);
      rdx(1'b1, `SWD_REG_TARGET, 32'h0);
      swd_host_model_i.wr(`SWD_REG_IRQ_CLR, 32'h7);
      $display("short divide test done");
   endtask

   task automatic t_word;
      swd_host_model_i.wr(`SWD_REG_AUXQ, 32'h5A5A5A5A);
      op(32'hFFFFFFF9, 32'h2, 32'h1);
      rdx(1'b1, `SWD_REG_TARGET, 32'hFFFFFFFD);
      rdx(1'b1, `SWD_REG_AUXQ, 32'h5A5A5A5A);
      rdx(1'b0, `SWD_REG_IRQ_STAT, 32'h4);
      rdx(1'b0, `SWD_REG_TARGET, `SWD_MOST_NEG);
      swd_host_model_i.wr(`SWD_REG_IRQ_CLR, 32'h7);
      $display("word divide test done");
   endtask

   // Carry preset to 1 throughout; no divide may touch it
   task automatic t_flags;
      logic [31:0] dd[6] = '{32'h5, 32'h5, 32'h9, 32'hFFFFFFF7, 32'h0, 32'h9};
      logic [31:0] dv[6] = '{32'h0, 32'h0, 32'h2, 32'h2, 32'h3, 32'h2};
      logic [31:0] ct[6] = '{32'h1, 32'h5, 32'hD, 32'h9, 32'h9, 32'h1};
      logic [31:0] ex[6] = '{32'h04, 32'h07, 32'h55, 32'h4D, 32'h65, 32'h65};
      swd_host_model_i.wr(`SWD_REG_FLAGS, 32'h4);
      for (int i = 0; i < 6; i++)
      begin
         op(dd[i], dv[i], ct[i]);
         rdx(1'b1, `SWD_REG_FLAGS, ex[i]);
      end
      rdx(1'b0, `SWD_REG_FLAGS, 32'h4);
      op(`SWD_MOST_NEG, `SWD_MINUS_ONE, 32'h7);
      rdx(1'b0, `SWD_REG_FLAGS, 32'h7);
      swd_host_model_i.wr(`SWD_REG_IRQ_CLR, 32'h7);
      $display("flags test done");
   endtask

   task automatic t_irq;
      swd_host_model_i.wr(`SWD_REG_IRQ_EN, 32'h1);
      op(32'h8, 32'h2, 32'h3);
      chk({31'h0, irq_old}, 32'h1);
      chk({31'h0, irq_new}, 32'h0);
      swd_host_model_i.wr(`SWD_REG_IRQ_CLR, 32'h1);
      @(negedge ref_clk_in);
      chk({31'h0, irq_old}, 32'h0);
      swd_host_model_i.wr(`SWD_REG_IRQ_EN, 32'h0);
      op(32'h8, 32'h2, 32'h3);
      chk({31'h0, irq_old}, 32'h0);
      rdx(1'b0, `SWD_REG_IRQ_STAT, 32'h1);
      swd_host_model_i.wr(`SWD_REG_IRQ_EN, 32'h1);
      @(negedge ref_clk_in);
      chk({31'h0, irq_old}, 32'h1);
      swd_host_model_i.wr(`SWD_REG_IRQ_CLR, 32'h7);
      rdx(1'b0, `SWD_REG_IRQ_CLR, 32'h0);
      rdx(1'b0, 4'hF, 32'h0);
      $display("interrupt test done");
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      t_short;
      t_word;
      t_flags;
      t_irq;
      results;
   end

   // Sixteen divides of about 40 cycles plus bus traffic; ample margin
   initial
   begin
      #100000;
      fail_count++;
      results;
   end
endmodule // swd_divide_unit_tb_top
`default_nettype wire

// ---- testbench/swd_host_model.sv ----
// Issue-side model: drives the register port of both divide units
`timescale 1ns/1ns
`default_nettype none

module swd_host_model (
   // Clock
   input  wire logic        ref_clk_in,
   // Register port
   output logic [3:0]       addr_out,
   output logic [31:0]      wdata_out,
   output logic             write_out,
   output logic             read_out,
   input  wire logic [31:0] rdata_old_in,
   input  wire logic [31:0] rdata_new_in
);
   initial
   begin
      addr_out = 4'h0;
      wdata_out = 32'h0;
      write_out = 1'b0;
      read_out = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      wdata_out <= d;
      write_out <= 1'b1;
      @(posedge ref_clk_in);
      write_out <= 1'b0;
      // Idle data flips so stale values never look valid
      wdata_out <= ~d;
   endtask

   task automatic rd(input logic sel, input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      read_out <= 1'b1;
      @(posedge ref_clk_in);
      read_out <= 1'b0;
      #1;
      d = sel ? rdata_new_in : rdata_old_in;
   endtask
endmodule // swd_host_model
`default_nettype wire

// ---- testbench/swd_monitor.sv ----
// Port checker for the signed word divide unit
`timescale 1ns/1ns
`default_nettype none
`include "swd_defs.vh"

module swd_monitor #(
   parameter [0:0] FAMILY = `SWD_FAMILY_OLD
) (
   // Clock and reset
   input wire logic                   ref_clk_in,
   input wire logic                   reset_n_in,
   // Register port and status
   input wire logic [`SWD_ADDR_W-1:0] addr_in,
   input wire logic [31:0]            wdata_in,
   input wire logic                   write_in,
   input wire logic                   read_in,
   input wire logic [31:0]            rdata_out,
   input wire logic                   busy_out,
   input wire logic                   irq_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   wire logic go = write_in && addr_in == `SWD_REG_CTRL && wdata_in[`SWD_CTRL_START] && !busy_out;
   wire logic go_ok = go && (wdata_in[`SWD_CTRL_SHORT] == !FAMILY);

   property p_legal_start; go_ok |=> busy_out; endproperty
   a_legal_start: assert property (p_legal_start) else $error("legal start did not raise busy");
   property p_illegal_idle; go && !go_ok |=> !busy_out; endproperty
   a_illegal_idle: assert property (p_illegal_idle) else $error("illegal op went busy");
   property p_busy_cause; $rose(busy_out) |-> $past(go_ok); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a legal start");
   property p_busy_hold; $rose(busy_out) |-> busy_out [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_busy_end; $rose(busy_out) |-> ##[30:40] !busy_out; endproperty
   a_busy_end: assert property (p_busy_end) else $error("divide took too long");
   property p_rdata_idle; !read_in |=> rdata_out == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
   property p_clr_zero; read_in && addr_in >= `SWD_REG_IRQ_CLR |=> rdata_out == 32'h0; endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear or unmapped read not zero");
   property p_flags_busy;
      read_in && addr_in == `SWD_REG_FLAGS |=> rdata_out[`SWD_FLG_BUSY] == $past(busy_out) && rdata_out[31:8] == 24'h0;
   endproperty
   a_flags_busy: assert property (p_flags_busy) else $error("flags busy bit wrong");
   property p_irq_rise; $rose(irq_out) |-> $past(write_in) || $past(write_in, 2) || $past(busy_out); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_fall; $fell(irq_out) |-> $past(write_in); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule // swd_monitor

bind swd_divide_unit swd_monitor #(.FAMILY(FAMILY)) swd_monitor_i (.ref_clk_in(ref_clk_in),
   .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
   .rdata_out(rdata_out), .busy_out(busy_out), .irq_out(irq_out));
`default_nettype wire
